// ### core/adc_defs.svh
// offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
// register byte offsets on the apb bus
`define ADC_OFF_CTRL0 12'h000
`define ADC_OFF_CTRL1 12'h004
`define ADC_OFF_CTRL2 12'h008
`define ADC_OFF_RESH 12'h00c
`define ADC_OFF_RESL 12'h010
`define ADC_OFF_IRQ_STAT 12'h014
`define ADC_OFF_IRQ_EN 12'h018
`define ADC_OFF_IRQ_CLR 12'h01c
// control zero fields
`define ADC_ON_BIT 0
`define ADC_GO_BIT 1
`define ADC_CHAN_LSB 2
// control one fields
`define ADC_NREF_BIT 5
`define ADC_PREF_BIT 4
// control two fields
`define ADC_JUST_BIT 7
`define ADC_ACQ_LSB 3
// reset values of the pin config field
`define ADC_PCFG_RST_ANALOG 4'h0
`define ADC_PCFG_RST_MIXED 4'h7
// interrupt status bits
`define ADC_IRQ_DONE 0
`define ADC_IRQ_ABORT 1
// timing: core clock period and instruction cycle in ns
`define ADC_CLK_NS 25
`define ADC_TCY_NS 100
`define ADC_TCY_CLKS (`ADC_TCY_NS / `ADC_CLK_NS)
`define ADC_WAIT_TCY 2
`define ADC_WAIT_CLKS (`ADC_WAIT_TCY * `ADC_TCY_CLKS)
// core clocks per period of the internal rc clock model
`define ADC_RC_DIV 8'd40
// result width
`define ADC_RES_BITS 12
`endif

// ### core/adc_pkg.sv
// types of the converter control block
package adc_pkg;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } adc_apb_req_t;
  // controls toward the analog front end
  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] dac_code;
    logic sample;
    logic neg_ref_select;
    logic pos_ref_select;
    logic [12:0] pin_is_analog;
  } adc_ana_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RCDLY, ST_ACQ, ST_CONV, ST_WAIT
  } adc_state_t;
endpackage : adc_pkg

// ### core/adc_ctrl.sv
// converter control registers, apb slave and successive approximation sequencer
//
// The implementer's own choices: the register offsets and the APB register port.
`include "adc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire adc_pkg::adc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_in,
  input wire logic portb_analog_at_reset,
  input wire logic large_package,
  output adc_pkg::adc_ana_t ana,
  output logic irq
);
  import adc_pkg::*;

  // synchronisers for the pin inputs
  logic cmp_s1_ff, cmp_s2_ff;
  logic strap_s1_ff, strap_s2_ff;
  logic pkg_s1_ff, pkg_s2_ff;
  // control registers
  logic on_ff, nxt_on;
  logic go_ff, nxt_go;
  logic [3:0] chan_ff, nxt_chan;
  logic nref_ff, nxt_nref;
  logic pref_ff, nxt_pref;
  logic [3:0] pcfg_ff, nxt_pcfg;
  logic just_ff, nxt_just;
  logic [2:0] acq_ff, nxt_acq;
  logic [2:0] csel_ff, nxt_csel;
  // result pair
  logic [7:0] resh_ff, nxt_resh;
  logic [7:0] resl_ff, nxt_resl;
  // interrupt status and enable
  logic [1:0] ist_ff, nxt_ist;
  logic [1:0] ien_ff, nxt_ien;
  // sequencer
  adc_state_t st_ff, nxt_st;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] div_ff, nxt_div;
  logic [11:0] sar_ff, nxt_sar;
  logic [11:0] mask_ff, nxt_mask;
  logic [11:0] dac_ff, nxt_dac;
  // apb read data register
  logic [31:0] rd_ff, nxt_rd;

  // decode helpers
  logic wr, setup, mapped;
  logic tick;
  logic [7:0] div_len;
  logic [4:0] acq_len;
  logic [1:0] ev;
  logic [11:0] keep;
  logic [3:0] n_digital;

  // conversion clock divider length per select code
  function automatic logic [7:0] div_of(input logic [2:0] c);
    case (c)
      3'h0: div_of = 8'd2;
      3'h1: div_of = 8'd8;
      3'h2: div_of = 8'd32;
      3'h4: div_of = 8'd4;
      3'h5: div_of = 8'd16;
      3'h6: div_of = 8'd64;
      default: div_of = `ADC_RC_DIV;
    endcase
  endfunction : div_of

  // acquisition periods per select code
  function automatic logic [4:0] acq_of(input logic [2:0] c);
    case (c)
      3'h7: acq_of = 5'd20;
      3'h6: acq_of = 5'd16;
      3'h5: acq_of = 5'd12;
      3'h4: acq_of = 5'd8;
      3'h3: acq_of = 5'd6;
      3'h2: acq_of = 5'd4;
      3'h1: acq_of = 5'd2;
      default: acq_of = 5'd0;
    endcase
  endfunction : acq_of

  // two flip-flop synchronisers, data only so no reset
  always_ff @(posedge core_clk) begin
    cmp_s1_ff <= cmp_in;
    cmp_s2_ff <= cmp_s1_ff;
    strap_s1_ff <= portb_analog_at_reset;
    strap_s2_ff <= strap_s1_ff;
    pkg_s1_ff <= large_package;
    pkg_s2_ff <= pkg_s1_ff;
  end

  // bus decode
  always_comb begin
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= `ADC_OFF_IRQ_CLR);
    div_len = div_of(csel_ff);
    acq_len = acq_of(acq_ff);
    tick = (div_ff == div_len - 8'd1);
  end

  // registers and sequencer next values
  always_comb begin
    nxt_on = on_ff;
    nxt_go = go_ff;
    nxt_chan = chan_ff;
    nxt_nref = nref_ff;
    nxt_pref = pref_ff;
    nxt_pcfg = pcfg_ff;
    nxt_just = just_ff;
    nxt_acq = acq_ff;
    nxt_csel = csel_ff;
    nxt_resh = resh_ff;
    nxt_resl = resl_ff;
    nxt_ien = ien_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_div = tick ? 8'd0 : div_ff + 8'd1;
    nxt_sar = sar_ff;
    nxt_mask = mask_ff;
    nxt_dac = dac_ff;
    ev = 2'h0;
    keep = cmp_s2_ff ? dac_ff : (dac_ff & ~mask_ff);
    // software writes, upper unimplemented bits dropped
    if (wr) begin
      unique case (apb_req.paddr)
        `ADC_OFF_CTRL0: begin
          nxt_on = apb_req.pwdata[`ADC_ON_BIT];
          nxt_chan = apb_req.pwdata[`ADC_CHAN_LSB +: 4];
          if (apb_req.pwdata[`ADC_GO_BIT] && apb_req.pwdata[`ADC_ON_BIT] && !go_ff) begin
            nxt_go = 1'b1;
            nxt_st = (csel_ff[1:0] == 2'h3) ? ST_RCDLY : ST_ACQ;
            nxt_cnt = 8'd0;
            nxt_div = 8'd0;
          end
        end
        `ADC_OFF_CTRL1: begin
          nxt_nref = apb_req.pwdata[`ADC_NREF_BIT];
          nxt_pref = apb_req.pwdata[`ADC_PREF_BIT];
          nxt_pcfg = apb_req.pwdata[3:0];
        end
        `ADC_OFF_CTRL2: begin
          nxt_just = apb_req.pwdata[`ADC_JUST_BIT];
          nxt_acq = apb_req.pwdata[`ADC_ACQ_LSB +: 3];
          nxt_csel = apb_req.pwdata[2:0];
        end
        `ADC_OFF_RESH: nxt_resh = apb_req.pwdata[7:0];
        `ADC_OFF_RESL: nxt_resl = apb_req.pwdata[7:0];
        `ADC_OFF_IRQ_EN: nxt_ien = apb_req.pwdata[1:0];
        default: ;
      endcase
    end
    // sequencer
    unique case (st_ff)
      ST_IDLE: ;
      ST_RCDLY: begin
        // one instruction cycle before the rc clock runs
        nxt_div = 8'd0;
        nxt_cnt = cnt_ff + 8'd1;
        if (cnt_ff == 8'(`ADC_TCY_CLKS - 1)) begin
          nxt_st = ST_ACQ;
          nxt_cnt = 8'd0;
        end
      end
      ST_ACQ: begin
        // programmed acquisition, counted in conversion clock periods
        if (acq_len == 5'd0 || (tick && cnt_ff == {3'h0, acq_len} - 8'd1)) begin
          nxt_st = ST_CONV;
          nxt_cnt = 8'd0;
          nxt_div = 8'd0;
          nxt_mask = 12'h800;
          nxt_dac = 12'h800;
          nxt_sar = 12'h000;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 8'd1;
        end
      end
      ST_CONV: begin
        // one result bit per period; the comparator sits behind two flip-flops,
        // so a bit waits until its trial code has stood for three clocks
        // at the fastest divider this stretches each bit to two periods
        nxt_cnt = cnt_ff + 8'd1;
        if (tick && cnt_ff >= 8'd2) begin
          nxt_cnt = 8'd0;
          nxt_sar = keep;
          nxt_mask = mask_ff >> 1;
          nxt_dac = keep | (mask_ff >> 1);
          if (mask_ff == 12'h001) begin
            // result and go flag change in the same update
            nxt_go = 1'b0;
            ev[`ADC_IRQ_DONE] = 1'b1;
            nxt_resh = nxt_just ? {4'h0, keep[11:8]} : keep[11:4];
            nxt_resl = nxt_just ? keep[7:0] : {keep[3:0], 4'h0};
            nxt_st = ST_WAIT;
            nxt_cnt = 8'd0;
          end
        end
      end
      ST_WAIT: begin
        // settle for two instruction cycles before idle; a start written meanwhile is not held off
        nxt_cnt = cnt_ff + 8'd1;
        if (cnt_ff == 8'(`ADC_WAIT_CLKS - 1)) begin
          nxt_st = ST_IDLE;
        end
      end
    endcase
    // clearing go or the enable mid conversion aborts, results untouched
    if (go_ff && st_ff != ST_WAIT && st_ff != ST_IDLE && ev == 2'h0 &&
        ((wr && apb_req.paddr == `ADC_OFF_CTRL0 && !apb_req.pwdata[`ADC_GO_BIT]) ||
         !nxt_on)) begin
      nxt_go = 1'b0;
      nxt_st = ST_WAIT;
      nxt_cnt = 8'd0;
      nxt_resh = (wr && apb_req.paddr == `ADC_OFF_RESH) ? apb_req.pwdata[7:0] : resh_ff;
      nxt_resl = (wr && apb_req.paddr == `ADC_OFF_RESL) ? apb_req.pwdata[7:0] : resl_ff;
      ev[`ADC_IRQ_ABORT] = 1'b1;
    end
    // sticky status, a new event wins over a clear
    nxt_ist = ist_ff;
    if (wr && apb_req.paddr == `ADC_OFF_IRQ_CLR) begin
      nxt_ist = ist_ff & ~apb_req.pwdata[1:0];
    end
    nxt_ist = nxt_ist | ev;
  end

  // read data captured in the setup phase
  always_comb begin
    nxt_rd = rd_ff;
    if (setup) begin
      unique case (apb_req.paddr)
        `ADC_OFF_CTRL0: nxt_rd = {26'h0, chan_ff, go_ff & on_ff, on_ff};
        `ADC_OFF_CTRL1: nxt_rd = {26'h0, nref_ff, pref_ff, pcfg_ff};
        `ADC_OFF_CTRL2: nxt_rd = {24'h0, just_ff, 1'b0, acq_ff, csel_ff};
        `ADC_OFF_RESH: nxt_rd = {24'h0, resh_ff};
        `ADC_OFF_RESL: nxt_rd = {24'h0, resl_ff};
        `ADC_OFF_IRQ_STAT: nxt_rd = {30'h0, ist_ff};
        `ADC_OFF_IRQ_EN: nxt_rd = {30'h0, ien_ff};
        default: nxt_rd = 32'h0;
      endcase
    end
  end

  // register all state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      on_ff <= 1'b0;
      go_ff <= 1'b0;
      chan_ff <= 4'h0;
      nref_ff <= 1'b0;
      pref_ff <= 1'b0;
      pcfg_ff <= strap_s2_ff ? `ADC_PCFG_RST_ANALOG : `ADC_PCFG_RST_MIXED;
      just_ff <= 1'b0;
      acq_ff <= 3'h0;
      csel_ff <= 3'h0;
      resh_ff <= 8'h0;
      resl_ff <= 8'h0;
      ist_ff <= 2'h0;
      ien_ff <= 2'h0;
      st_ff <= ST_IDLE;
      cnt_ff <= 8'h0;
      div_ff <= 8'h0;
      sar_ff <= 12'h0;
      mask_ff <= 12'h0;
      dac_ff <= 12'h0;
      rd_ff <= 32'h0;
    end else begin
      on_ff <= nxt_on;
      go_ff <= nxt_go;
      chan_ff <= nxt_chan;
      nref_ff <= nxt_nref;
      pref_ff <= nxt_pref;
      pcfg_ff <= nxt_pcfg;
      just_ff <= nxt_just;
      acq_ff <= nxt_acq;
      csel_ff <= nxt_csel;
      resh_ff <= nxt_resh;
      resl_ff <= nxt_resl;
      ist_ff <= nxt_ist;
      ien_ff <= nxt_ien;
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      sar_ff <= nxt_sar;
      mask_ff <= nxt_mask;
      dac_ff <= nxt_dac;
      rd_ff <= nxt_rd;
    end
  end

  // number of inputs turned digital by the pin config code
  assign n_digital = (pcfg_ff <= 4'h2) ? 4'h0 : pcfg_ff - 4'h2;

  // per input analog flag, inputs 5 to 7 only on the large package
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_pin
      if (gi >= 5 && gi <= 7) begin : g_opt
        assign ana.pin_is_analog[gi] = pkg_s2_ff && (5'(gi) < 5'd13 - {1'b0, n_digital});
      end else begin : g_fix
        assign ana.pin_is_analog[gi] = (5'(gi) < 5'd13 - {1'b0, n_digital});
      end
    end
  endgenerate

  // analog front end controls; codes above 12 pass through and read a floating node
  assign ana.chan = chan_ff;
  assign ana.dac_code = dac_ff;
  assign ana.sample = on_ff && (st_ff == ST_IDLE || st_ff == ST_ACQ || st_ff == ST_RCDLY);
  assign ana.neg_ref_select = nref_ff;
  assign ana.pos_ref_select = pref_ff;

  // apb answer, zero wait states in the access phase
  assign prdata = rd_ff;
  assign pready = apb_req.psel & apb_req.penable;
  assign pslverr = apb_req.psel & apb_req.penable & ~mapped;

  // level interrupt from enabled sticky status
  assign irq = |(ist_ff & ien_ff);
endmodule : adc_ctrl
`default_nettype wire

// ### dv/adc_ctrl_monitor.sv
// port-level checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire adc_pkg::adc_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic portb_analog_at_reset,
  input wire logic large_package,
  input wire adc_pkg::adc_ana_t ana,
  input wire logic irq
);
  import adc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc; // access phase
  logic wr; // write access
  logic bad; // address outside the map or misaligned
  logic [12:0] pmask; // inputs that exist on this package
  assign pmask = large_package ? 13'h1fff : 13'h1f1f;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign bad = (apb_req.paddr > 12'h01c) | (apb_req.paddr[1:0] != 2'h0);
  // inputs left analog by a pin config code
  function automatic logic [12:0] amask(input logic [3:0] c);
    return (c < 4'h3) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction : amask
  a_bad_addr_err: assert property (acc && bad |-> pslverr)
    else $error("no error on bad address");
  a_err_only_bad: assert property (pslverr |-> acc && bad)
    else $error("error on good address");
  a_unimpl_read_zero: assert property (acc && !apb_req.pwrite && apb_req.paddr <= 12'h008
    |-> prdata[31:8] == 24'h0 && !prdata[6] && (apb_req.paddr == 12'h008 || !prdata[7]))
    else $error("unimplemented bits read set");
  a_chan_follows_write: assert property (wr && apb_req.paddr == 12'h000
    |=> ana.chan == $past(apb_req.pwdata[5:2])) else $error("channel not taken");
  a_ref_follows_write: assert property (wr && apb_req.paddr == 12'h004
    |=> {ana.neg_ref_select, ana.pos_ref_select} == $past(apb_req.pwdata[5:4]))
    else $error("reference selects not taken");
  a_pin_cfg_map: assert property (wr && apb_req.paddr == 12'h004
    |=> ana.pin_is_analog == (amask($past(apb_req.pwdata[3:0])) & pmask))
    else $error("pin config map wrong");
  a_cfg_hold_stable: assert property (!(wr && apb_req.paddr == 12'h004)
    |=> $stable({ana.neg_ref_select, ana.pos_ref_select, ana.pin_is_analog}))
    else $error("config changed without write");
  a_pcfg_reset_value: assert property ($fell(rst) |-> ana.pin_is_analog
    == ((portb_analog_at_reset ? 13'h1fff : 13'h00ff) & pmask)) else $error("pin config reset wrong");
  // main scenarios
  c_start: cover property (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[1:0] == 2'h3);
  c_irq: cover property ($rose(irq));
  c_bad: cover property (acc && bad);
endmodule : adc_ctrl_monitor
bind adc_ctrl adc_ctrl_monitor u_adc_ctrl_monitor (.core_clk(core_clk), .rst(rst),
  .apb_req(apb_req), .prdata(prdata), .pslverr(pslverr),
  .portb_analog_at_reset(portb_analog_at_reset), .large_package(large_package), .ana(ana),
  .irq(irq));
`default_nettype wire

// ### dv/adc_ana_model.sv
// analog side model: one input level compared with the trial code
`timescale 1ns/1ps
`default_nettype none
module adc_ana_model (
  input wire adc_pkg::adc_ana_t ana,
  input wire logic [11:0] vin,
  output logic cmp_in
);
  import adc_pkg::*;
  // comparator high while the input is at or above the trial code
  assign cmp_in = (vin >= ana.dac_code);
endmodule : adc_ana_model
`default_nettype wire

// ### dv/adc_ctrl_bench.sv
// self-checking bench of the converter control block
`include "adc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_bench;
  import adc_pkg::*;
  logic core_clk, rst, cmp_in, strap, irq, pready, pslverr, er;
  logic pkg; // large package strap
  adc_apb_req_t req; // apb request
  adc_ana_t ana; // front end controls
  logic [31:0] prdata, rd;
  logic [11:0] vin; // analog level of the model
  integer n_errors, checks, seed, n, k, t, eh, el;
  integer dv [8] = '{2, 8, 32, 40, 4, 16, 64, 40}; // clocks per conversion period
  integer aq [8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // acquisition periods
  adc_ctrl u_adc_ctrl (.core_clk(core_clk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .portb_analog_at_reset(strap),
    .large_package(pkg), .ana(ana), .irq(irq));
  adc_ana_model u_adc_ana_model (.ana(ana), .vin(vin), .cmp_in(cmp_in));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // read and compare
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // watchdog
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  initial begin
    req = '0;
    rst = 1'b1;
    strap = 1'b1;
    pkg = 1'b1;
    vin = 12'h0;
    n_errors = 0;
    checks = 0;
    seed = 31343;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(`ADC_OFF_CTRL1, 32'h0);
    // random register readback
    for (k = 0; k < 6; k++) begin
      t = $random(seed);
      apb(1'b1, `ADC_OFF_CTRL1, t);
      rdchk(`ADC_OFF_CTRL1, t & 8'h3f);
      apb(1'b1, `ADC_OFF_CTRL2, t);
      rdchk(`ADC_OFF_CTRL2, t & 8'hbf);
      apb(1'b1, `ADC_OFF_CTRL0, t & 8'hfd);
      rdchk(`ADC_OFF_CTRL0, t & 8'h3d);
      apb(1'b1, `ADC_OFF_RESL, t);
      rdchk(`ADC_OFF_RESL, t & 8'hff);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h002, 32'hff);
    chk(er, 1'b1);
    // one conversion per clock and acquisition code
    apb(1'b1, `ADC_OFF_IRQ_EN, 32'h1);
    // the fastest divider spends two periods per bit behind the comparator sync
    for (k = 0; k < 8; k++) begin
      vin = 12'($random(seed));
      t = (aq[k] + ((k == 0) ? 24 : 12)) * dv[k] + ((k == 3 || k == 7) ? 4 : 0);
      apb(1'b1, `ADC_OFF_CTRL2, (k[0] << 7) | (k << 3) | k);
      apb(1'b1, `ADC_OFF_CTRL0, 32'h3 | (k << 2));
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      chk(n >= t && n <= t + 3, 1'b1);
      rdchk(`ADC_OFF_CTRL0, 32'h1 | (k << 2));
      rdchk(`ADC_OFF_RESH, k[0] ? vin >> 8 : vin >> 4);
      rdchk(`ADC_OFF_RESL, k[0] ? vin & 8'hff : (vin & 4'hf) << 4);
      apb(1'b1, `ADC_OFF_IRQ_CLR, 32'h1);
      @(posedge core_clk);
      chk(irq, 1'b0);
    end
    eh = vin >> 8;
    el = vin & 8'hff;
    // abort a slow conversion, abort event masked first
    apb(1'b1, `ADC_OFF_CTRL2, 32'h3e);
    apb(1'b1, `ADC_OFF_CTRL0, 32'h3);
    rdchk(`ADC_OFF_CTRL0, 32'h3);
    apb(1'b1, `ADC_OFF_CTRL0, 32'h1);
    rdchk(`ADC_OFF_RESH, eh);
    rdchk(`ADC_OFF_RESL, el);
    rdchk(`ADC_OFF_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, `ADC_OFF_IRQ_EN, 32'h3);
    @(posedge core_clk);
    chk(irq, 1'b1);
    apb(1'b1, `ADC_OFF_IRQ_CLR, 32'h3);
    @(posedge core_clk);
    chk(irq, 1'b0);
    // start refused while the converter is off
    apb(1'b1, `ADC_OFF_CTRL0, 32'h2);
    rdchk(`ADC_OFF_CTRL0, 32'h0);
    rdchk(`ADC_OFF_IRQ_STAT, 32'h0);
    // second reset with the strap low
    strap <= 1'b0;
    @(posedge core_clk);
    rst <= 1'b1;
    pkg <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(`ADC_OFF_CTRL1, 32'h7);
    chk({19'h0, ana.pin_is_analog}, 32'h1f);
    tally_and_finish;
  end
endmodule : adc_ctrl_bench
`default_nettype wire
